// [rtl/spi_fram_protect_pkg.sv]
package spi_fram_protect_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 11;
  localparam int          MEM_DEPTH  = 2048;
  localparam logic [10:0] ADDR_TOP   = 11'h7FF;
  localparam logic [10:0] QUARTER_LO = 11'h600;
  localparam logic [10:0] HALF_LO    = 11'h400;
  localparam logic [10:0] ALL_LO     = 11'h000;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WRITE        = 8'h02;

  // ----------------------------------------------------------------
  // protection_status layout and reset values
  // ----------------------------------------------------------------
  localparam int         SR_LATCH_BIT   = 1;
  localparam int         SR_GUARD_LO    = 2;
  localparam int         SR_GUARD_HI    = 3;
  localparam int         SR_HONOR_BIT   = 7;
  localparam logic [7:0] SR_FIXED_MASK  = 8'h71;
  localparam logic [7:0] SR_RESET       = 8'h00;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  // ----------------------------------------------------------------
  // Transfer phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE   = 4'h0,
    PH_OPCODE = 4'h1,
    PH_ADDR_H = 4'h2,
    PH_ADDR_L = 4'h3,
    PH_WDATA  = 4'h4,
    PH_RDATA  = 4'h5,
    PH_SFETCH = 4'h6,
    PH_SSTORE = 4'h7,
    PH_IGNORE = 4'h8,
    PH_DONE   = 4'h9
  } phase_e;

endpackage : spi_fram_protect_pkg

// [rtl/spi_fram_protect_access.sv]
// Overview of operation
// - Status bits 0,4-6 always read zero.
// - Write latch at bit 1, zero at power-up.
// - Only the latch-set command sets the write latch.
// - Block-guard bits persist across power cycles.
// - Guard pair selects none, quarter, half, all.
// - Guard pin ignored when pin-honour bit zero.
// - Status write refused if honour set, pin low.
// - Array write needs latch and unguarded address.
// - Status fetch returns exactly one status byte.
// - Executed status store clears the write latch.
// - Two address bytes, MSB first, low 11 used.
// - Burst write stores bytes, address wraps 7FFh.
// - Byte committed after eighth clock; partial dropped.
// - Guarded address stops increment, drops remaining bytes.
// - Read data on next eight clocks, input ignored.
// - Burst read MSB first, address wraps.
// - Chip select rise ends read, output off.
// - Hold low freezes, hold high resumes operation.
// - Six fixed opcode encodings.
// - Select rise after writes clears latch.
// - Unknown opcode: ignore input, output off.
// - Sample at clock rise, drive at fall.
`timescale 1ns/1ps
`default_nettype none

module spi_fram_protect_access
  import spi_fram_protect_pkg::*;
(
  input  wire logic i_sys_clk,   // 200 MHz system clock
  input  wire logic i_sys_rst,   // Synchronous reset, models power-up
  input  wire logic i_cs_n,      // Chip select, active low
  input  wire logic i_sck,       // Serial clock from master
  input  wire logic i_si,        // Serial data in
  input  wire logic i_wp_n,      // Write-guard pin, active low
  input  wire logic i_hold_n,    // Hold pin, active low
  output var  logic o_so,        // Serial data out
  output var  logic o_so_oe      // Serial out enable, high drives
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cs_m;
    logic        cs_s;
    logic        cs_p;
    logic        sck_m;
    logic        sck_s;
    logic        sck_p;
    logic        si_m;
    logic        si_s;
    logic        wp_m;
    logic        wp_s;
    logic        hold_m;
    logic        hold_s;
    phase_e      phase;
    logic [2:0]  bit_cnt;
    logic [7:0]  in_sh;
    logic [7:0]  out_sh;
    logic [10:0] addr;
    logic        is_read;
    logic        clr_pend;
    logic        latch;
    logic        honor;
    logic        guard_hi;
    logic        guard_lo;
    logic        so;
    logic        so_oe;
  } state_s;

  localparam state_s ST_INIT = '{
    cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, sck_m: 1'b0, sck_s: 1'b0,
    sck_p: 1'b0, si_m: 1'b0, si_s: 1'b0, wp_m: 1'b1, wp_s: 1'b1,
    hold_m: 1'b1, hold_s: 1'b1, phase: PH_IDLE, bit_cnt: 3'h0,
    in_sh: 8'h00, out_sh: 8'h00, addr: 11'h000, is_read: 1'b0,
    clr_pend: 1'b0, latch: SR_RESET[SR_LATCH_BIT],
    honor: SR_RESET[SR_HONOR_BIT], guard_hi: SR_RESET[SR_GUARD_HI],
    guard_lo: SR_RESET[SR_GUARD_LO], so: 1'b0, so_oe: 1'b0};

  state_s st_q = ST_INIT;
  state_s st_d;

  logic [7:0]  mem [MEM_DEPTH];
  logic        mem_we;
  logic [10:0] mem_wa;
  logic [7:0]  mem_wd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic guarded(input logic hi, input logic lo, input logic [10:0] a);
    case ({hi, lo})
      2'b01:   guarded = (a >= QUARTER_LO);
      2'b10:   guarded = (a >= HALF_LO);
      2'b11:   guarded = (a >= ALL_LO);
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  function automatic logic [7:0] status_byte(input state_s s);
    status_byte = 8'h00;
    status_byte[SR_HONOR_BIT] = s.honor;
    status_byte[SR_GUARD_HI]  = s.guard_hi;
    status_byte[SR_GUARD_LO]  = s.guard_lo;
    status_byte[SR_LATCH_BIT] = s.latch;
  endfunction : status_byte

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       sr_ok;

  assign cs_fall   = !st_q.cs_s && st_q.cs_p;
  assign cs_rise   = st_q.cs_s && !st_q.cs_p;
  // Held: clock edges are not seen, so the transfer resumes where it paused
  assign sck_rise  = st_q.sck_s && !st_q.sck_p && !st_q.cs_s && st_q.hold_s;
  assign sck_fall  = !st_q.sck_s && st_q.sck_p && !st_q.cs_s && st_q.hold_s;
  assign byte_in   = {st_q.in_sh[6:0], st_q.si_s};
  assign byte_done = sck_rise && (st_q.bit_cnt == BIT_LAST);
  assign sr_ok     = st_q.latch && !(st_q.honor && !st_q.wp_s);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    mem_we      = 1'b0;
    mem_wa      = st_q.addr;
    mem_wd      = byte_in;
    st_d.cs_m   = i_cs_n;
    st_d.cs_s   = st_q.cs_m;
    st_d.cs_p   = st_q.cs_s;
    st_d.sck_m  = i_sck;
    st_d.sck_s  = st_q.sck_m;
    st_d.sck_p  = st_q.sck_s;
    st_d.si_m   = i_si;
    st_d.si_s   = st_q.si_m;
    st_d.wp_m   = i_wp_n;
    st_d.wp_s   = st_q.wp_m;
    st_d.hold_m = i_hold_n;
    st_d.hold_s = st_q.hold_m;

    if (cs_rise) begin
      st_d.phase    = PH_IDLE;
      st_d.so_oe    = 1'b0;
      st_d.clr_pend = 1'b0;
      if (st_q.clr_pend) begin
        st_d.latch = 1'b0;
      end
    end else if (cs_fall) begin
      st_d.phase    = PH_OPCODE;
      st_d.bit_cnt  = 3'h0;
      st_d.clr_pend = 1'b0;
      st_d.so_oe    = 1'b0;
    end else begin
      if (sck_rise) begin
        st_d.in_sh   = byte_in;
        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
      end
      if (sck_fall && (st_q.phase == PH_RDATA || st_q.phase == PH_SFETCH)) begin
        st_d.so     = st_q.out_sh[7];
        st_d.so_oe  = 1'b1;
        st_d.out_sh = {st_q.out_sh[6:0], 1'b0};
      end else if (sck_fall) begin
        st_d.so_oe  = 1'b0;
      end
      if (byte_done) begin
        case (st_q.phase)
          PH_OPCODE: begin
            case (byte_in)
              OP_LATCH_SET: begin
                st_d.latch = 1'b1;
                st_d.phase = PH_DONE;
              end
              OP_LATCH_CLEAR: begin
                st_d.clr_pend = 1'b1;
                st_d.phase    = PH_DONE;
              end
              OP_STATUS_FETCH: begin
                st_d.out_sh = status_byte(st_q);
                st_d.phase  = PH_SFETCH;
              end
              OP_STATUS_STORE: begin
                st_d.phase = PH_SSTORE;
              end
              OP_READ: begin
                st_d.is_read = 1'b1;
                st_d.phase   = PH_ADDR_H;
              end
              OP_WRITE: begin
                st_d.is_read = 1'b0;
                st_d.phase   = PH_ADDR_H;
              end
              default: begin
                st_d.phase = PH_IGNORE;
              end
            endcase
          end
          PH_ADDR_H: begin
            st_d.addr[10:8] = byte_in[2:0];
            st_d.phase      = PH_ADDR_L;
          end
          PH_ADDR_L: begin
            st_d.addr[7:0] = byte_in;
            if (st_q.is_read) begin
              st_d.out_sh = mem[{st_q.addr[10:8], byte_in}];
              st_d.phase  = PH_RDATA;
            end else begin
              st_d.clr_pend = 1'b1;
              st_d.phase    = PH_WDATA;
            end
          end
          PH_WDATA: begin
            // A guarded address is neither written nor advanced past
            if (st_q.latch && !guarded(st_q.guard_hi, st_q.guard_lo, st_q.addr)) begin
              mem_we    = 1'b1;
              st_d.addr = st_q.addr + 11'h001;
            end
          end
          PH_RDATA: begin
            st_d.addr   = st_q.addr + 11'h001;
            st_d.out_sh = mem[st_q.addr + 11'h001];
          end
          PH_SFETCH: begin
            st_d.phase = PH_DONE;
          end
          PH_SSTORE: begin
            // Master must have set the latch in an earlier select cycle
            if (sr_ok) begin
              st_d.honor    = byte_in[SR_HONOR_BIT];
              st_d.guard_hi = byte_in[SR_GUARD_HI];
              st_d.guard_lo = byte_in[SR_GUARD_LO];
            end
            st_d.clr_pend = 1'b1;
            st_d.phase    = PH_DONE;
          end
          default: begin
            st_d.phase = st_q.phase;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q       <= ST_INIT;
      // Guard and honour bits are nonvolatile and survive power-up
      st_q.honor    <= st_q.honor;
      st_q.guard_hi <= st_q.guard_hi;
      st_q.guard_lo <= st_q.guard_lo;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign o_so    = st_q.so;
  assign o_so_oe = st_q.so_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence cs_rise_seq;
    !st_q.cs_p ##0 st_q.cs_s;
  endsequence

  sequence clr_armed_seq;
    st_q.clr_pend && !st_q.cs_s;
  endsequence

  fixed_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (byte_done && !cs_fall && st_q.phase == PH_OPCODE && byte_in == OP_STATUS_FETCH)
      |=> (st_q.out_sh & SR_FIXED_MASK) == 8'h00)
    else $error("fixed status bits not zero");

  latch_set_src_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(st_q.latch) |-> $past(byte_done && st_q.phase == PH_OPCODE
                                && byte_in == OP_LATCH_SET))
    else $error("write latch set without latch-set command");

  array_guard_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    mem_we |-> st_q.latch && !guarded(st_q.guard_hi, st_q.guard_lo, mem_wa))
    else $error("array write to guarded address or without latch");

  status_guard_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !$stable({st_q.honor, st_q.guard_hi, st_q.guard_lo})
      |-> $past(st_q.latch && !(st_q.honor && !st_q.wp_s)))
    else $error("status write accepted while refused");

  latch_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (clr_armed_seq ##1 cs_rise_seq) |=> !st_q.latch)
    else $error("write latch not cleared on select rise");

  out_release_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    cs_rise_seq |=> !o_so_oe ##1 !o_so_oe)
    else $error("serial out still driven after select rise");

  bad_opcode_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (st_q.phase == PH_IGNORE) |-> ##1 !o_so_oe)
    else $error("serial out driven after unknown opcode");

  hold_freeze_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (!st_q.hold_s && !st_q.cs_s && st_q.cs_p == st_q.cs_s)
      |=> $stable(st_q.bit_cnt) && $stable(st_q.addr))
    else $error("transfer advanced while held");

  burst_step_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    mem_we |=> st_q.addr == $past(st_q.addr) + 11'h001)
    else $error("write address did not advance by one");

  power_latch_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> !st_q.latch)
    else $error("write latch set after power-up");

  store_latch_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (byte_done && st_q.phase == PH_SSTORE) |=> st_q.latch == $past(st_q.latch))
    else $error("status payload changed the write latch");

  guard_stop_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (byte_done && !cs_fall && st_q.phase == PH_WDATA
     && guarded(st_q.guard_hi, st_q.guard_lo, st_q.addr)) |-> !mem_we ##1 $stable(st_q.addr))
    else $error("guarded burst write not stopped");

  write_wrap_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (mem_we && mem_wa == ADDR_TOP) |=> st_q.addr == ALL_LO)
    else $error("write address did not wrap to zero");

  read_step_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (byte_done && !cs_fall && st_q.phase == PH_RDATA)
      |=> st_q.addr == $past(st_q.addr) + 11'h001)
    else $error("read address did not advance by one");

endmodule : spi_fram_protect_access

`default_nettype wire

// [tb/spi_master_model.sv]
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  output var  logic o_cs_n,   // Chip select to device
  output var  logic o_sck,    // Serial clock
  output var  logic o_si,     // Serial data to device
  output var  logic o_hold_n, // Hold request
  input  wire logic i_so,     // Serial data from device
  input  wire logic i_so_oe   // Device drives serial data
);
  localparam time HALF = 24ns;

  logic mode3;   // Clock idles high between frames
  logic oe_seen; // Device drove data during the last byte

  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
    oe_seen  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame and bit timing
  // ----------------------------------------------------------------
  task automatic frame_start;
    o_sck = mode3;
    #HALF o_cs_n = 1'b0;
    #HALF;
  endtask : frame_start

  // Clock stands still at its idle level outside frames
  task automatic frame_end;
    o_sck = mode3;
    #HALF o_cs_n = 1'b1;
    o_si = ~o_si;
    #(4 * HALF);
  endtask : frame_end

  // Sends nb bits MSB first; a hold pause is taken inside bit hb
  task automatic xfer(input logic [7:0] tx, input int nb, input int hb,
                      output logic [7:0] rx);
    rx      = 8'h00;
    oe_seen = 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_sck = 1'b0;
      o_si  = tx[7-i];
      #HALF;
      if (i == hb) begin
        o_hold_n = 1'b0;
        #HALF o_sck = 1'b1;
        #HALF o_sck = 1'b0;
        #HALF o_hold_n = 1'b1;
        #HALF;
      end
      o_sck   = 1'b1;
      rx[7-i] = i_so;
      oe_seen = oe_seen | i_so_oe;
      #HALF;
    end
  endtask : xfer

endmodule : spi_master_model

`default_nettype wire

// [tb/tb_spi_fram_protect_access.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_spi_fram_protect_access;
  import spi_fram_protect_pkg::*;

  logic        i_sys_clk;
  logic        i_sys_rst;
  logic        i_wp_n;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        hold_n;
  logic        o_so;
  logic        o_so_oe;
  logic        so_pin;
  logic [7:0]  rx;
  logic [7:0]  gv;
  logic [10:0] base[3];
  logic [7:0]  exp1[3];
  int          num_errors;
  int          compares;

  // Released line shows a changing pattern instead of a stale level
  assign so_pin = o_so_oe ? o_so : ~sck;

  always #2.5 i_sys_clk = ~i_sys_clk;

  spi_fram_protect_access dut (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_cs_n    (cs_n),
    .i_sck     (sck),
    .i_si      (si),
    .i_wp_n    (i_wp_n),
    .i_hold_n  (hold_n),
    .o_so      (o_so),
    .o_so_oe   (o_so_oe)
  );

  spi_master_model m (
    .o_cs_n   (cs_n),
    .o_sck    (sck),
    .o_si     (si),
    .o_hold_n (hold_n),
    .i_so     (so_pin),
    .i_so_oe  (o_so_oe)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close;
    m.frame_end();
    chk("oe_off", 8'h00, {7'h00, o_so_oe});
  endtask : close

  task automatic cmd(input logic [7:0] op);
    m.frame_start();
    m.xfer(op, 8, 9, rx);
    close();
  endtask : cmd

  task automatic store(input logic [7:0] v);
    m.frame_start();
    m.xfer(OP_STATUS_STORE, 8, 9, rx);
    m.xfer(v, 8, 9, rx);
    close();
  endtask : store

  task automatic fetch(input logic [7:0] exp);
    m.frame_start();
    m.xfer(OP_STATUS_FETCH, 8, 9, rx);
    m.xfer(8'hFF, 8, 9, rx);
    chk("status", exp, rx);
    m.xfer(8'hFF, 8, 9, rx);
    chk("extra_oe", 8'h00, {7'h00, m.oe_seen});
    close();
  endtask : fetch

  // Upper five address bits are sent as ones
  task automatic addr(input logic [7:0] op, input logic [10:0] a);
    m.frame_start();
    m.xfer(op, 8, 9, rx);
    m.xfer({5'h1F, a[10:8]}, 8, 9, rx);
    m.xfer(a[7:0], 8, 9, rx);
  endtask : addr

  task automatic wr(input logic [10:0] a, input logic [7:0] d[$], input logic part);
    addr(OP_WRITE, a);
    foreach (d[i]) m.xfer(d[i], 8, 9, rx);
    if (part) m.xfer(8'hFF, 4, 9, rx);
    close();
  endtask : wr

  task automatic rd(input logic [10:0] a, input logic [7:0] e[$], input int hb);
    addr(OP_READ, a);
    foreach (e[i]) begin
      m.xfer(8'h5A, 8, (i == 1) ? hb : 9, rx);
      chk("read", e[i], rx);
    end
    close();
  endtask : rd

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #400us;
    num_errors++;
    test_done();
  end

  initial begin
    i_sys_clk  = 1'b0;
    i_sys_rst  = 1'b1;
    i_wp_n     = 1'b1;
    m.mode3    = 1'b0;
    num_errors = 0;
    compares   = 0;
    base       = '{11'h5FF, 11'h3FF, 11'h3FF};
    exp1       = '{8'hC3, 8'hC1, 8'hC1};
    repeat (6) @(posedge i_sys_clk);
    #1.2 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1.2;
    m.mode3 = 1'b1;
    fetch(SR_RESET);
    store(8'hFF);
    fetch(8'h00);
    cmd(OP_LATCH_SET);
    fetch(8'h02);
    cmd(OP_LATCH_CLEAR);
    fetch(8'h00);
    cmd(OP_LATCH_SET);
    m.frame_start();
    m.xfer(8'hFF, 8, 9, rx);
    m.xfer(OP_LATCH_CLEAR, 8, 9, rx);
    chk("unknown_oe", 8'h00, {7'h00, m.oe_seen});
    close();
    fetch(8'h02);
    store(8'hFF);
    fetch(8'h8C);
    i_wp_n = 1'b0;
    cmd(OP_LATCH_SET);
    store(8'h00);
    fetch(8'h8C);
    i_wp_n = 1'b1;
    cmd(OP_LATCH_SET);
    store(8'h00);
    fetch(8'h00);
    i_wp_n = 1'b0;
    cmd(OP_LATCH_SET);
    store(8'h80);
    fetch(8'h80);
    m.mode3 = 1'b0;
    cmd(OP_LATCH_SET);
    wr(11'h000, '{8'h11, 8'h22}, 1'b0);
    fetch(8'h80);
    cmd(OP_LATCH_SET);
    wr(11'h7FE, '{8'h33, 8'h44, 8'h55}, 1'b1);
    rd(11'h7FE, '{8'h33, 8'h44, 8'h55, 8'h22}, 3);
    wr(11'h000, '{8'h99}, 1'b0);
    rd(11'h000, '{8'h55}, 9);
    cmd(OP_LATCH_SET);
    wr(11'h3FF, '{8'hC0, 8'hC1}, 1'b0);
    cmd(OP_LATCH_SET);
    wr(11'h5FF, '{8'hC2, 8'hC3}, 1'b0);
    for (int g = 1; g < 4; g++) begin
      gv     = 8'(g);
      i_wp_n = 1'b1;
      cmd(OP_LATCH_SET);
      store(8'h80 | (gv << 2));
      i_wp_n = 1'b0;
      cmd(OP_LATCH_SET);
      wr(base[g-1], '{gv, gv}, 1'b0);
      rd(base[g-1], '{(g == 3) ? 8'h02 : gv, exp1[g-1]}, 9);
    end
    @(posedge i_sys_clk);
    #1.2 i_sys_rst = 1'b1;
    @(posedge i_sys_clk);
    #1.2 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1.2;
    fetch(8'h8C);
    test_done();
  end

endmodule : tb_spi_fram_protect_access

`default_nettype wire
